/* File: adcmx_pkg.sv */
package adcmx_pkg;
  localparam int DATA_W = 16;
  localparam int CHAN_W = 3;
  localparam int MUX_W = 4;
  localparam int OS_W = 3;
  localparam int CNT_W = 8;
  localparam logic [MUX_W-1:0] MUX_DIAG = 4'h8;
  localparam logic [1:0] LPF_OPT1 = 2'h0;
  localparam logic [1:0] LPF_OPT2 = 2'h1;
  localparam logic [1:0] LPF_OPT3 = 2'h2;
  localparam logic [1:0] LPF_RSVD = 2'h3;
  localparam logic [1:0] RNG_SOFTWARE = 2'h0;
  localparam logic [OS_W-1:0] OS_OFF = 3'h0;
  localparam logic [CNT_W-1:0] ONE_SAMPLE = 8'h01;
  localparam int CLK_PERIOD_PS = 25000;
  localparam int ACQ_TIME_NS = 1000;
  localparam int ACQ_CYC =
    (ACQ_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [CNT_W-1:0] ACQ_LAST = CNT_W'(ACQ_CYC - 1);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACQ,
    ST_CONV,
    ST_FIN
  } adcmx_state_e;
endpackage

/* File: adcmx_avg.sv */
`timescale 1ns/1ps
module adcmx_avg #(
  parameter int DATA_W = 16,
  parameter int OS_W = 3
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic smp_vld_i,
  input wire logic dump_i,
  input wire logic [OS_W-1:0] shift_i,
  input wire logic [2*DATA_W-1:0] data_i,
  output logic [2*DATA_W-1:0] avg_o
);
  localparam int ACC_W = DATA_W + (1 << OS_W);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_conv
      logic signed [ACC_W-1:0] acc_ff;
      logic signed [DATA_W-1:0] raw_ff;
      logic signed [ACC_W-1:0] shifted;
      logic signed [DATA_W-1:0] smp;
      logic signed [DATA_W-1:0] avg_ff;

      assign smp = data_i[g*DATA_W +: DATA_W];
      assign shifted = acc_ff >>> shift_i;

      // accumulate each sample; dumping restarts the sum
      always_ff @(posedge ref_clk_i) begin
        if (srst_i || dump_i) begin
          acc_ff <= '0;
        end else if (smp_vld_i) begin
          acc_ff <= acc_ff + ACC_W'(smp);
        end
      end

      always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
          raw_ff <= '0;
        end else if (smp_vld_i) begin
          raw_ff <= smp;
        end
      end

      // ratio of two to the shift: divide, then cut back to the word width
      always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
          avg_ff <= '0;
        end else if (dump_i) begin
          if (shift_i == '0) begin
            avg_ff <= raw_ff;
          end else begin
            avg_ff <= shifted[DATA_W-1:0];
          end
        end
      end

      assign avg_o[g*DATA_W +: DATA_W] = avg_ff;
    end
  endgenerate
endmodule // adcmx_avg

/* File: adcmx_ctrl.sv */
// Functional notes
// - filter choice only in software mode: 00 opt1, 01 opt2, 10 opt3.
// - each converter mux: eight external channels plus internal diagnostic.
// - hardware mode: select pins caught at reset release give first pair.
// - hardware mode: select pins read during conversion pick next pair.
// - hardware mode never routes the diagnostic channels.
// - software mode takes channel selection from register fields.
// - sequencer and burst work in both modes without host selection.
// - ratio from ratio pins in hardware, register field in software.
// - one ratio applies to every channel converted.
// - code 000 disables; 001..111 give ratios 2 to 128.
// - one result per channel only after all its samples.
// - first sample taken on rising edge of conversion start.
// - remaining samples started by internal strobe, no host edges.
// - samples averaged and decimated to one 16-bit word.
// - with burst sequencing all samples finish before channel advances.
// - averaging filter bypassed entirely when oversampling is off.
// - hardware pairs A and B of same index; software any pairing.
// - both range pins low means software mode, else hardware.
`timescale 1ns/1ps
module adcmx_ctrl #(
  parameter int DATA_W = adcmx_pkg::DATA_W,
  parameter int ACQ_CYC = adcmx_pkg::ACQ_CYC
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [1:0] range_select_pins_i,
  input wire logic [adcmx_pkg::CHAN_W-1:0] channel_select_pins_i,
  input wire logic [adcmx_pkg::OS_W-1:0] oversample_ratio_pins_i,
  input wire logic conversion_start_input_i,
  input wire logic [adcmx_pkg::MUX_W-1:0] sw_chan_a_i,
  input wire logic [adcmx_pkg::MUX_W-1:0] sw_chan_b_i,
  input wire logic sw_diag_sel_i,
  input wire logic [1:0] sw_lpf_i,
  input wire logic [adcmx_pkg::OS_W-1:0] averaging_ratio_field_i,
  input wire logic seq_en_i,
  input wire logic burst_en_i,
  input wire logic [adcmx_pkg::CHAN_W-1:0] seq_last_i,
  input wire logic adc_done_i,
  input wire logic [DATA_W-1:0] adc_data_a_i,
  input wire logic [DATA_W-1:0] adc_data_b_i,
  output logic sw_mode_o,
  output logic [adcmx_pkg::MUX_W-1:0] mux_sel_a_o,
  output logic [adcmx_pkg::MUX_W-1:0] mux_sel_b_o,
  output logic diag_sel_o,
  output logic [1:0] lpf_sel_o,
  output logic adc_start_o,
  output logic busy_o,
  output logic result_valid_o,
  output logic [DATA_W-1:0] result_a_o,
  output logic [DATA_W-1:0] result_b_o
);
  localparam int CNT_W = adcmx_pkg::CNT_W;
  localparam int MUX_W = adcmx_pkg::MUX_W;
  localparam int CHAN_W = adcmx_pkg::CHAN_W;
  localparam logic [CNT_W-1:0] ACQ_LAST = CNT_W'(ACQ_CYC - 1);

  adcmx_pkg::adcmx_state_e st_ff;
  logic rst_d_ff;
  logic conv_d_ff;
  logic sw_mode_ff;
  logic [adcmx_pkg::OS_W-1:0] os_code_ff;
  logic [CNT_W-1:0] acq_cnt_ff;
  logic [CNT_W-1:0] smp_cnt_ff;
  logic [CHAN_W-1:0] pend_sel_ff;
  logic [CHAN_W-1:0] seq_idx_ff;
  logic [MUX_W-1:0] mux_a_ff;
  logic [MUX_W-1:0] mux_b_ff;
  logic adc_start_ff;
  logic fin_ff;
  logic [2*DATA_W-1:0] avg;
  logic release_p;
  logic start_edge;
  logic last_smp;
  logic seq_end;
  logic burst_more;
  logic [CNT_W-1:0] n_smp;
  logic [CHAN_W-1:0] nxt_seq_idx;
  logic [MUX_W-1:0] sw_a;
  logic [MUX_W-1:0] sw_b;
  logic [adcmx_pkg::OS_W-1:0] nxt_os_code;
  logic [CHAN_W-1:0] rel_sel;
  logic [CNT_W-1:0] gap_ff;

  assign release_p = rst_d_ff && !srst_i;
  assign start_edge = conversion_start_input_i && !conv_d_ff;
  assign n_smp = adcmx_pkg::ONE_SAMPLE << os_code_ff;
  assign last_smp = (smp_cnt_ff + adcmx_pkg::ONE_SAMPLE) == n_smp;
  assign seq_end = seq_idx_ff == seq_last_i;
  assign burst_more = seq_en_i && burst_en_i && !seq_end;
  assign nxt_seq_idx = seq_end ? '0 : seq_idx_ff + 1'b1;
  // codes past the diagnostic slot all land on it
  assign sw_a = (sw_chan_a_i > adcmx_pkg::MUX_DIAG) ?
                adcmx_pkg::MUX_DIAG : sw_chan_a_i;
  assign sw_b = (sw_chan_b_i > adcmx_pkg::MUX_DIAG) ?
                adcmx_pkg::MUX_DIAG : sw_chan_b_i;
  assign nxt_os_code = sw_mode_ff ? averaging_ratio_field_i :
                       oversample_ratio_pins_i;
  // mode is not latched yet at release, so decode the range pins directly
  assign rel_sel = (range_select_pins_i == adcmx_pkg::RNG_SOFTWARE) ?
                   '0 : channel_select_pins_i;

  always_ff @(posedge ref_clk_i) begin
    rst_d_ff <= srst_i;
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      conv_d_ff <= 1'b1;
    end else begin
      conv_d_ff <= conversion_start_input_i;
    end
  end

  // mode is fixed by the range pins seen as reset releases
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sw_mode_ff <= 1'b0;
    end else if (release_p) begin
      sw_mode_ff <=
        range_select_pins_i == adcmx_pkg::RNG_SOFTWARE;
    end
  end

  // sequencing state machine
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_ff <= adcmx_pkg::ST_IDLE;
      acq_cnt_ff <= '0;
      smp_cnt_ff <= '0;
      adc_start_ff <= 1'b0;
      fin_ff <= 1'b0;
      os_code_ff <= adcmx_pkg::OS_OFF;
    end else begin
      adc_start_ff <= 1'b0;
      fin_ff <= 1'b0;
      case (st_ff)
        adcmx_pkg::ST_IDLE: begin
          if (start_edge && !release_p) begin
            adc_start_ff <= 1'b1;
            os_code_ff <= nxt_os_code;
            smp_cnt_ff <= '0;
            st_ff <= adcmx_pkg::ST_CONV;
          end
        end
        adcmx_pkg::ST_ACQ: begin
          if (acq_cnt_ff == ACQ_LAST) begin
            adc_start_ff <= 1'b1;
            st_ff <= adcmx_pkg::ST_CONV;
          end else begin
            acq_cnt_ff <= acq_cnt_ff + 1'b1;
          end
        end
        adcmx_pkg::ST_CONV: begin
          if (adc_done_i) begin
            acq_cnt_ff <= '0;
            smp_cnt_ff <= smp_cnt_ff + 1'b1;
            if (last_smp) begin
              st_ff <= adcmx_pkg::ST_FIN;
            end else begin
              st_ff <= adcmx_pkg::ST_ACQ;
            end
          end
        end
        adcmx_pkg::ST_FIN: begin
          fin_ff <= 1'b1;
          smp_cnt_ff <= '0;
          if (burst_more) begin
            st_ff <= adcmx_pkg::ST_ACQ;
          end else begin
            st_ff <= adcmx_pkg::ST_IDLE;
          end
        end
        default: begin
          st_ff <= adcmx_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // select pins are watched throughout a conversion for the next pair
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pend_sel_ff <= '0;
    end else if (release_p || st_ff == adcmx_pkg::ST_CONV) begin
      pend_sel_ff <= channel_select_pins_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      seq_idx_ff <= '0;
    end else if (release_p) begin
      seq_idx_ff <= rel_sel;
    end else if (st_ff == adcmx_pkg::ST_FIN && seq_en_i) begin
      seq_idx_ff <= nxt_seq_idx;
    end
  end

  // mux routing; hardware mode only ever sees matching pairs 0..7
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      mux_a_ff <= '0;
      mux_b_ff <= '0;
    end else if (release_p) begin
      mux_a_ff <= {1'b0, rel_sel};
      mux_b_ff <= {1'b0, rel_sel};
    end else if (st_ff == adcmx_pkg::ST_FIN) begin
      if (seq_en_i) begin
        mux_a_ff <= {1'b0, nxt_seq_idx};
        mux_b_ff <= {1'b0, nxt_seq_idx};
      end else if (!sw_mode_ff) begin
        mux_a_ff <= {1'b0, pend_sel_ff};
        mux_b_ff <= {1'b0, pend_sel_ff};
      end else begin
        mux_a_ff <= sw_a;
        mux_b_ff <= sw_b;
      end
    end else if (st_ff == adcmx_pkg::ST_IDLE && sw_mode_ff && !seq_en_i) begin
      mux_a_ff <= sw_a;
      mux_b_ff <= sw_b;
    end
  end

  adcmx_avg #(
    .DATA_W(DATA_W),
    .OS_W(adcmx_pkg::OS_W)
  ) u_avg (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .smp_vld_i(st_ff == adcmx_pkg::ST_CONV && adc_done_i),
    .dump_i(st_ff == adcmx_pkg::ST_FIN),
    .shift_i(os_code_ff),
    .data_i({adc_data_b_i, adc_data_a_i}),
    .avg_o(avg)
  );

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sw_mode_o <= 1'b0;
      mux_sel_a_o <= '0;
      mux_sel_b_o <= '0;
      diag_sel_o <= 1'b0;
      lpf_sel_o <= adcmx_pkg::LPF_OPT1;
      busy_o <= 1'b0;
    end else begin
      sw_mode_o <= sw_mode_ff;
      mux_sel_a_o <= mux_a_ff;
      mux_sel_b_o <= mux_b_ff;
      diag_sel_o <= sw_mode_ff && sw_diag_sel_i;
      // reserved code 11 falls back to the first option
      if (!sw_mode_ff || sw_lpf_i == adcmx_pkg::LPF_RSVD) begin
        lpf_sel_o <= adcmx_pkg::LPF_OPT1;
      end else begin
        lpf_sel_o <= sw_lpf_i;
      end
      busy_o <= st_ff != adcmx_pkg::ST_IDLE;
    end
  end

  assign adc_start_o = adc_start_ff;
  assign result_valid_o = fin_ff;
  assign result_a_o = avg[DATA_W-1:0];
  assign result_b_o = avg[2*DATA_W-1:DATA_W];

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_conv_done;
    st_ff == adcmx_pkg::ST_CONV && adc_done_i && !last_smp;
  endsequence

  // cycles since the last finished conversion, for the strobe check
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || (st_ff == adcmx_pkg::ST_CONV && adc_done_i)) begin
      gap_ff <= '0;
    end else if (gap_ff != '1) begin
      gap_ff <= gap_ff + 1'b1;
    end
  end

  a_hw_no_diag: assert property (
    !sw_mode_o |-> mux_sel_a_o < adcmx_pkg::MUX_DIAG && !diag_sel_o)
    else $error("diagnostic routed in hardware mode");
  a_hw_same_pair: assert property (
    !sw_mode_o |-> mux_sel_a_o == mux_sel_b_o)
    else $error("hardware pair mismatch");
  a_hw_lpf_fixed: assert property (
    !sw_mode_o |-> lpf_sel_o == adcmx_pkg::LPF_OPT1)
    else $error("filter option changed in hardware mode");
  a_first_on_edge: assert property (
    st_ff == adcmx_pkg::ST_IDLE && start_edge && !release_p |=> adc_start_o)
    else $error("start edge not followed by conversion");
  a_strobe_after_acq: assert property (
    adc_start_o && $past(st_ff) == adcmx_pkg::ST_ACQ |->
      gap_ff >= CNT_W'(ACQ_CYC))
    else $error("internal strobe too early");
  a_strobe_bounded: assert property (
    s_conv_done |-> ##[2:300] adc_start_o)
    else $error("internal strobe missing");
  a_os_off_one: assert property (
    st_ff == adcmx_pkg::ST_CONV && adc_done_i &&
      os_code_ff == adcmx_pkg::OS_OFF |=> st_ff == adcmx_pkg::ST_FIN)
    else $error("extra samples with oversampling off");
  a_result_count: assert property (
    result_valid_o |-> $past(smp_cnt_ff, 2) == n_smp - 1'b1)
    else $error("result before all samples taken");
  a_mux_steady: assert property (
    $changed(mux_a_ff) && st_ff != adcmx_pkg::ST_IDLE |->
      $past(st_ff) == adcmx_pkg::ST_FIN)
    else $error("channel advanced before samples gathered");
  a_ratio_steady: assert property (
    st_ff != adcmx_pkg::ST_IDLE |=> $stable(os_code_ff))
    else $error("ratio changed mid channel");
endmodule // adcmx_ctrl

/* File: adcmx_conv_model.sv */
`timescale 1ns/1ps
module adcmx_conv_model (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic slow_i,
  input wire logic start_i,
  input wire logic [3:0] mux_a_i,
  input wire logic [3:0] mux_b_i,
  output logic done_o,
  output logic [15:0] data_a_o,
  output logic [15:0] data_b_o
);
  logic [3:0] cnt_ff;
  logic busy_ff;
  logic [15:0] seq_ff;
  logic [15:0] val_a_ff;
  logic [15:0] val_b_ff;
  // word encodes mux selection plus a running sample count
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cnt_ff <= 4'h0;
      busy_ff <= 1'b0;
      seq_ff <= 16'h0000;
      done_o <= 1'b0;
      val_a_ff <= 16'h0000;
      val_b_ff <= 16'h0000;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        busy_ff <= 1'b1;
        cnt_ff <= slow_i ? 4'h9 : 4'h3;
        val_a_ff <= {4'h0, mux_a_i, 8'h00} + seq_ff;
        val_b_ff <= 16'h4000 + {4'h0, mux_b_i, 8'h00} + seq_ff;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - 4'h1;
        if (cnt_ff == 4'h1) begin
          done_o <= 1'b1;
          busy_ff <= 1'b0;
          seq_ff <= seq_ff + 16'h0001;
        end
      end
    end
  end
  // data is only held for the done cycle
  assign data_a_o = done_o ? val_a_ff : ~val_a_ff;
  assign data_b_o = done_o ? val_b_ff : ~val_b_ff;
endmodule // adcmx_conv_model

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic ref_clk_i, srst_i, start, sw_diag, seq_en, burst_en, slow, done;
  logic [1:0] rng, sw_lpf, lpf_sel;
  logic [2:0] chsel, os_pins, os_fld, seq_last;
  logic [3:0] sw_a, sw_b, mux_a, mux_b;
  logic [15:0] da, db, res_a, res_b;
  logic sw_mode, diag_sel, adc_start, busy, res_vld, sw_m;
  int fails, check_count, cycles, nconv;
  adcmx_ctrl #(.ACQ_CYC(4)) adcmx_ctrl_i (.ref_clk_i(ref_clk_i),
    .srst_i(srst_i), .range_select_pins_i(rng),
    .channel_select_pins_i(chsel), .oversample_ratio_pins_i(os_pins),
    .conversion_start_input_i(start), .sw_chan_a_i(sw_a), .sw_chan_b_i(sw_b),
    .sw_diag_sel_i(sw_diag), .sw_lpf_i(sw_lpf),
    .averaging_ratio_field_i(os_fld), .seq_en_i(seq_en),
    .burst_en_i(burst_en), .seq_last_i(seq_last), .adc_done_i(done),
    .adc_data_a_i(da), .adc_data_b_i(db), .sw_mode_o(sw_mode),
    .mux_sel_a_o(mux_a), .mux_sel_b_o(mux_b), .diag_sel_o(diag_sel),
    .lpf_sel_o(lpf_sel), .adc_start_o(adc_start), .busy_o(busy),
    .result_valid_o(res_vld), .result_a_o(res_a), .result_b_o(res_b));
  adcmx_conv_model adcmx_conv_model_i (.ref_clk_i(ref_clk_i),
    .srst_i(srst_i), .slow_i(slow), .start_i(adc_start), .mux_a_i(mux_a),
    .mux_b_i(mux_b), .done_o(done), .data_a_o(da), .data_b_o(db));
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  task automatic tick;
    @(posedge ref_clk_i);
    #2;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic rst(input logic [1:0] r, input logic [2:0] sel);
    srst_i = 1'b1;
    rng = r;
    chsel = sel;
    repeat (3) tick();
    srst_i = 1'b0;
    repeat (3) tick();
    nconv = 0;
    sw_m = (r == 2'h0);
  endtask
  // one host start plus a second start pulse mid-conversion; nch channels of 2^code samples each are expected
  task automatic convert(input int nch, input int code, input int ia,
                         input int ib, input logic [2:0] nxt, input bit dc);
    int n, starts, res, cyc, lst;
    logic [15:0] ea, eb;
    n = 1 << code;
    starts = 0;
    lst = 0;
    res = 0;
    cyc = 0;
    os_fld = sw_m ? 3'(code) : 3'h7;
    os_pins = sw_m ? 3'h7 : 3'(code);
    tick();
    start = 1'b1;
    while (res < nch && cyc < 4000) begin
      tick();
      cyc++;
      if (cyc == 1) start = 1'b0;
      if (cyc == 1) chsel = nxt;
      if (cyc == 4) start = 1'b1;
      if (cyc == 5) start = 1'b0;
      if (cyc == 2) chk(busy, 1'b1);
      if (adc_start === 1'b1) begin
        // four acquisition cycles after a conversion of at least five
        if (starts > 0) chk(cyc - lst >= 9, 1'b1);
        lst = cyc;
        starts++;
      end
      if (res_vld === 1'b1) begin
        ea = 16'((ia + res) * 256 + nconv + (n - 1) / 2);
        eb = 16'(16'h4000 + (ib + res) * 256 + nconv + (n - 1) / 2);
        if (dc) chk(res_a, ea);
        if (dc) chk(res_b, eb);
        nconv += n;
        res++;
      end
    end
    chk(starts, nch * n);
    chk(res, nch);
    tick();
    tick();
    chk(busy, 1'b0);
  endtask
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    {srst_i, start, sw_diag, seq_en, burst_en, slow} = 6'h20;
    {rng, sw_lpf, chsel, os_pins, os_fld, seq_last} = 16'h0000;
    sw_a = 4'h3;
    sw_b = 4'h6;
    fails = 0;
    check_count = 0;
    cycles = 0;
    rst(2'h0, 3'h0);
    chk(sw_mode, 1'b1);
    for (int c = 0; c < 4; c++) begin
      sw_lpf = 2'(c);
      repeat (3) tick();
      chk(lpf_sel, (c == 3) ? 2'h0 : 2'(c));
    end
    for (int c = 0; c < 8; c++) convert(1, c, 3, 6, 3'h1, 1);
    chk(mux_a, 4'h3);
    chk(mux_b, 4'h6);
    sw_a = 4'h9;
    sw_diag = 1'b1;
    convert(1, 0, 8, 6, 3'h0, 0);
    chk(mux_a, adcmx_pkg::MUX_DIAG);
    chk(diag_sel, 1'b1);
    sw_lpf = 2'h2;
    for (int r = 1; r < 4; r++) begin
      rst(2'(r), 3'h5);
      chk(sw_mode, 1'b0);
    end
    chk(mux_a, 4'h5);
    chk(mux_b, 4'h5);
    chk(lpf_sel, 2'h0);
    chk(diag_sel, 1'b0);
    slow = 1'b1;
    convert(1, 2, 5, 5, 3'h2, 1);
    chk(mux_a, 4'h2);
    convert(1, 1, 2, 2, 3'h7, 1);
    chk(mux_b, 4'h7);
    slow = 1'b0;
    sw_a = 4'h0;
    sw_b = 4'h0;
    sw_diag = 1'b0;
    rst(2'h0, 3'h3);
    seq_en = 1'b1;
    burst_en = 1'b1;
    seq_last = 3'h2;
    convert(3, 1, 0, 0, 3'h0, 1);
    end_sim();
  end
endmodule // tb_top
